// >>> hw/clock_dist_update_ctrl.v
// How it works
// - Two bits of the function register pick the shared pin role: 00 reset, 01 sync, 11 power-down, 10 forbidden.
// - Writing one to the update bit copies all buffered values to the active registers on the next serial clock rise.
// - The update bit clears itself after the copy, so no zero write is needed.
// - A divider set to bypass is powered down automatically.
// - The delay element on the fifth clock output is powered down when it is not in the path.
// - Each clock output has its own power-down control.
// - The whole distribution section can be powered down as one unit.
// - Power-down and power-up of a block keep its register programming.
// - Soft sync high holds outputs and its high-to-low edge triggers a sync.
`include "clock_dist_regs.vh"

module clock_dist_update_ctrl (
  input wire sys_clk,
  input wire reset,
  input wire sclk,
  input wire csb_n,
  input wire sdio_in,
  output wire sdio_out,
  output wire sdio_oe,
  input wire func_pin_n,
  output reg chip_reset_req,
  output reg chip_powerdown,
  output reg sync_hold,
  output reg sync_pulse,
  output reg sync_lost,
  output reg sync_detect_en,
  output reg sync_select,
  output reg dist_ref_pd,
  output reg sync_block_pd,
  output reg [4:0] divider_bypass,
  output reg [4:0] divider_pd,
  output reg delay_in_path,
  output reg delay_pd,
  output reg [4:0] out_pd,
  output reg [2:0] pecl_full_off
);

  wire sclk_rise;
  wire wr_stb;
  wire [7:0] addr;
  wire addr_ok;
  wire [7:0] wdata;
  reg [7:0] rdata;

  // Buffered copies written by the serial port
  reg [7:0] fn_buf_r;
  reg [4:0] byp_buf_r;
  reg [4:0] opd_buf_r;
  reg dsel_buf_r;
  reg [2:0] poff_buf_r;
  reg upd_pending_r;
  reg upd_pending_nxt;

  // Active copies that steer the hardware
  reg [7:0] fn_act_r;
  reg hold_q_r;
  reg sync_lost_nxt;
  reg [1:0] role;
  reg pin_reset;
  reg pin_pd;
  reg hold_nxt;
  reg transfer;
  reg pd_rise;

  // One decode per register, shared by the buffer and strobe logic
  reg wr_fn;
  reg wr_upd;
  reg wr_byp;
  reg wr_opd;
  reg wr_dsel;
  reg wr_poff;

  serial_ctrl_slave u_port (
    .sys_clk(sys_clk),
    .reset(reset),
    .sclk(sclk),
    .csb_n(csb_n),
    .sdio_in(sdio_in),
    .rdata(rdata),
    .sdio_out(sdio_out),
    .sdio_oe(sdio_oe),
    .sclk_rise_r(sclk_rise),
    .wr_stb_r(wr_stb),
    .addr_r(addr),
    .addr_ok_r(addr_ok),
    .wdata_r(wdata)
  );

  function is_wr;
    input [7:0] a;
    input [7:0] target;
    input stb;
    input ok;
    begin
      is_wr = stb & ok & (a == target);
    end
  endfunction

  always @* begin
    wr_fn = is_wr(addr, `FUNC_SYNC_CTRL_ADDR, wr_stb, addr_ok);
    wr_upd = is_wr(addr, `UPDATE_STROBE_ADDR, wr_stb, addr_ok);
    wr_byp = is_wr(addr, `DIV_BYPASS_ADDR, wr_stb, addr_ok);
    wr_opd = is_wr(addr, `OUT_PD_ADDR, wr_stb, addr_ok);
    wr_dsel = is_wr(addr, `DELAY_SEL_ADDR, wr_stb, addr_ok);
    wr_poff = is_wr(addr, `PECL_OFF_ADDR, wr_stb, addr_ok);
    role = fn_act_r[`FN_ROLE_HI:`FN_ROLE_LO];
    pin_reset = (role == `ROLE_RESET) & ~func_pin_n;
    pin_pd = (role == `ROLE_PD) & ~func_pin_n;
    // Test code 10 leaves the pin without effect
    hold_nxt = ((role == `ROLE_SYNC) & ~func_pin_n) | fn_act_r[`FN_SOFT_SYNC];
    // Copy happens on the serial clock rise after the strobe write
    transfer = upd_pending_r & sclk_rise;
    pd_rise = transfer & (((byp_buf_r & ~divider_bypass) != 5'h00)
      | ((opd_buf_r & ~out_pd) != 5'h00)
      | (~dsel_buf_r & delay_in_path)
      | (fn_buf_r[`FN_DIST_REF_PD] & ~dist_ref_pd)
      | (fn_buf_r[`FN_SYNC_PD] & ~sync_block_pd));
    pd_rise = pd_rise | (pin_pd & ~chip_powerdown);
    // Set wins over the clear from a sync
    // A sync edge one cycle after a power-down clears it again, as it realigns
    if (pd_rise) begin
      sync_lost_nxt = 1'b1;
    end else if (hold_q_r & ~hold_nxt) begin
      sync_lost_nxt = 1'b0;
    end else begin
      sync_lost_nxt = sync_lost;
    end
    // A new strobe write wins over a pending clear
    if (wr_upd & wdata[`UPD_BIT]) begin
      upd_pending_nxt = 1'b1;
    end else if (transfer) begin
      upd_pending_nxt = 1'b0;
    end else begin
      upd_pending_nxt = upd_pending_r;
    end
    // Reads return the buffered values, and the status register the live flags; unused bits read zero
    rdata = 8'h00;
    if (addr_ok) begin
      case (addr)
        `FUNC_SYNC_CTRL_ADDR: rdata = fn_buf_r & `FN_USED_MASK;
        `UPDATE_STROBE_ADDR: rdata = {7'h00, upd_pending_r};
        `DIV_BYPASS_ADDR: rdata = {3'h0, byp_buf_r};
        `OUT_PD_ADDR: rdata = {3'h0, opd_buf_r};
        `DELAY_SEL_ADDR: rdata = {7'h00, dsel_buf_r};
        `PECL_OFF_ADDR: rdata = {5'h00, poff_buf_r};
        `STATUS_ADDR: rdata = {4'h0, chip_powerdown, sync_hold, sync_lost, chip_reset_req};
        default: rdata = 8'h00;
      endcase
    end
  end

  always @(posedge sys_clk) begin
    chip_reset_req <= reset | pin_reset;
    if (reset | pin_reset) begin
      fn_buf_r <= `FN_RESET;
      byp_buf_r <= `DIV_BYPASS_RESET;
      opd_buf_r <= `OUT_PD_RESET;
      dsel_buf_r <= `DELAY_SEL_RESET;
      poff_buf_r <= `PECL_OFF_RESET;
      upd_pending_r <= 1'b0;
      fn_act_r <= `FN_RESET;
      divider_bypass <= `DIV_BYPASS_RESET;
      divider_pd <= `DIV_BYPASS_RESET;
      out_pd <= `OUT_PD_RESET;
      delay_in_path <= `DELAY_SEL_RESET;
      delay_pd <= 1'b1;
      pecl_full_off <= `PECL_OFF_RESET;
      dist_ref_pd <= 1'b0;
      sync_block_pd <= 1'b0;
      sync_detect_en <= 1'b0;
      sync_select <= 1'b0;
      chip_powerdown <= 1'b0;
      sync_hold <= 1'b0;
      sync_pulse <= 1'b0;
      sync_lost <= 1'b0;
      hold_q_r <= 1'b0;
    end else begin
      // Writes land in the buffer only; hardware sees them after an update
      if (wr_fn) begin
        fn_buf_r <= wdata & `FN_USED_MASK;
      end
      if (wr_byp) begin
        byp_buf_r <= wdata[4:0];
      end
      if (wr_opd) begin
        opd_buf_r <= wdata[4:0];
      end
      if (wr_dsel) begin
        dsel_buf_r <= wdata[0];
      end
      if (wr_poff) begin
        poff_buf_r <= wdata[2:0];
      end
      upd_pending_r <= upd_pending_nxt;
      // Bypassed dividers and an unselected delay line drop out with the copy
      if (transfer) begin
        fn_act_r <= fn_buf_r;
        divider_bypass <= byp_buf_r;
        divider_pd <= byp_buf_r;
        out_pd <= opd_buf_r;
        delay_in_path <= dsel_buf_r;
        delay_pd <= ~dsel_buf_r;
        pecl_full_off <= poff_buf_r;
        dist_ref_pd <= fn_buf_r[`FN_DIST_REF_PD];
        sync_block_pd <= fn_buf_r[`FN_SYNC_PD];
        sync_detect_en <= fn_buf_r[`FN_SYNC_DET_EN];
        sync_select <= fn_buf_r[`FN_SYNC_SELECT];
      end
      // No power-down path clears the buffers or active copies
      chip_powerdown <= pin_pd;
      hold_q_r <= hold_nxt;
      sync_hold <= hold_nxt;
      sync_pulse <= hold_q_r & ~hold_nxt;
      sync_lost <= sync_lost_nxt;
    end
  end

endmodule // clock_dist_update_ctrl

// >>> hw/clock_dist_regs.vh
`ifndef CLOCK_DIST_REGS_VH
`define CLOCK_DIST_REGS_VH

// Register offsets
`define FUNC_SYNC_CTRL_ADDR 8'h58
`define RESERVED_ADDR 8'h59
`define UPDATE_STROBE_ADDR 8'h5a
`define DIV_BYPASS_ADDR 8'h60
`define OUT_PD_ADDR 8'h61
`define DELAY_SEL_ADDR 8'h62
`define PECL_OFF_ADDR 8'h63
`define STATUS_ADDR 8'h64

// Fields of function_and_sync_control
`define FN_SYNC_DET_EN 0
`define FN_SYNC_SELECT 1
`define FN_SOFT_SYNC 2
`define FN_DIST_REF_PD 3
`define FN_SYNC_PD 4
`define FN_ROLE_LO 5
`define FN_ROLE_HI 6
`define FN_USED_MASK 8'h7f

// Shared pin roles
`define ROLE_RESET 2'b00
`define ROLE_SYNC 2'b01
`define ROLE_TEST 2'b10
`define ROLE_PD 2'b11

// Update strobe field
`define UPD_BIT 0

// Field widths and reset values
`define NUM_OUTPUTS 5
`define NUM_PECL 3
`define FN_RESET 8'h00
`define DIV_BYPASS_RESET 5'h00
`define OUT_PD_RESET 5'h00
`define DELAY_SEL_RESET 1'b0
`define PECL_OFF_RESET 3'h0

// Serial frame sizes
`define INSTR_BITS 16
`define DATA_BITS 8
`define INSTR_READ_BIT 15

`endif

// >>> hw/serial_ctrl_slave.v
`include "clock_dist_regs.vh"

module serial_ctrl_slave (
  input wire sys_clk,
  input wire reset,
  input wire sclk,
  input wire csb_n,
  input wire sdio_in,
  input wire [7:0] rdata,
  output reg sdio_out,
  output reg sdio_oe,
  output reg sclk_rise_r,
  output reg wr_stb_r,
  output reg [7:0] addr_r,
  output reg addr_ok_r,
  output reg [7:0] wdata_r
);

  localparam [3:0] S_IDLE = 4'b0001;
  localparam [3:0] S_INSTR = 4'b0010;
  localparam [3:0] S_DATA = 4'b0100;
  localparam [3:0] S_DONE = 4'b1000;

  reg [3:0] state_r;
  reg sclk_q_r;
  reg [4:0] cnt_r;
  reg [15:0] shift_r;
  reg rd_r;
  reg [7:0] rd_shift_r;
  wire rise = sclk & ~sclk_q_r;
  wire fall = ~sclk & sclk_q_r;

  always @(posedge sys_clk) begin
    if (reset) begin
      state_r <= S_IDLE;
      sclk_q_r <= 1'b0;
      cnt_r <= 5'h00;
      shift_r <= 16'h0000;
      rd_r <= 1'b0;
      rd_shift_r <= 8'h00;
      sdio_out <= 1'b0;
      sdio_oe <= 1'b0;
      sclk_rise_r <= 1'b0;
      wr_stb_r <= 1'b0;
      addr_r <= 8'h00;
      addr_ok_r <= 1'b0;
      wdata_r <= 8'h00;
    end else begin
      sclk_q_r <= sclk;
      sclk_rise_r <= rise;
      wr_stb_r <= 1'b0;
      if (csb_n) begin
        // Frame abort or end releases the line
        state_r <= S_IDLE;
        sdio_oe <= 1'b0;
        cnt_r <= 5'h00;
      end else begin
        case (state_r)
          S_IDLE: begin
            state_r <= S_INSTR;
            cnt_r <= 5'h00;
          end
          S_INSTR: begin
            if (rise) begin
              shift_r <= {shift_r[14:0], sdio_in};
              if (cnt_r == `INSTR_BITS - 1) begin
                cnt_r <= 5'h00;
                rd_r <= shift_r[`INSTR_READ_BIT - 1];
                addr_r <= {shift_r[6:0], sdio_in};
                addr_ok_r <= (shift_r[11:7] == 5'h00);
                state_r <= S_DATA;
              end else begin
                cnt_r <= cnt_r + 5'h01;
              end
            end
          end
          S_DATA: begin
            // Read data is launched on falling edges for the host to catch on rising
            if (rd_r && fall) begin
              sdio_oe <= 1'b1;
              sdio_out <= (cnt_r == 5'h00) ? rdata[7] : rd_shift_r[7];
              rd_shift_r <= (cnt_r == 5'h00) ? {rdata[6:0], 1'b0}
                                              : {rd_shift_r[6:0], 1'b0};
            end
            if (rise) begin
              shift_r <= {shift_r[14:0], sdio_in};
              if (cnt_r == `DATA_BITS - 1) begin
                state_r <= S_DONE;
                wr_stb_r <= ~rd_r;
                wdata_r <= {shift_r[6:0], sdio_in};
              end
              cnt_r <= cnt_r + 5'h01;
            end
          end
          S_DONE: begin
            if (fall) begin
              sdio_oe <= 1'b0;
            end
          end
          default: state_r <= S_IDLE;
        endcase
      end
    end
  end

endmodule // serial_ctrl_slave

// >>> bench/update_ctrl_asserts.sv
module update_ctrl_asserts (
  input wire sys_clk,
  input wire reset,
  input wire csb_n,
  input wire sdio_oe,
  input wire chip_reset_req,
  input wire chip_powerdown,
  input wire sync_hold,
  input wire sync_pulse,
  input wire sync_lost,
  input wire dist_ref_pd,
  input wire [4:0] divider_bypass,
  input wire [4:0] divider_pd,
  input wire delay_in_path,
  input wire delay_pd
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  div_pd_match_a: assert property (divider_pd == divider_bypass)
    else $error("divider power-down differs from bypass");
  delay_pd_match_a: assert property (delay_pd == !delay_in_path)
    else $error("delay power-down differs from select");
  reset_req_start_a: assert property ($fell(reset) |-> chip_reset_req)
    else $error("reset request missing after release");
  pulse_once_a: assert property (sync_pulse |=> !sync_pulse)
    else $error("sync pulse longer than one cycle");
  pulse_cause_a: assert property (sync_pulse |-> !sync_hold &&
    ($past(sync_hold) || $past(sync_hold, 2))) else $error("sync pulse without hold fall");
  dist_pd_lost_a: assert property ($rose(dist_ref_pd) |-> ##[0:2] sync_lost)
    else $error("distribution power-down kept sync");
  pin_pd_lost_a: assert property ($rose(chip_powerdown) |-> ##[0:2] sync_lost)
    else $error("pin power-down kept sync");
  roles_excl_a: assert property (!(chip_powerdown && chip_reset_req))
    else $error("two pin roles active");
  oe_release_a: assert property (csb_n [*3] |-> !sdio_oe)
    else $error("data line driven while deselected");
  cover property (sync_pulse);
  cover property ($rose(chip_powerdown));
  cover property ($rose(sync_lost));
endmodule // update_ctrl_asserts

bind clock_dist_update_ctrl update_ctrl_asserts i_chk (.*);

// >>> bench/host_port.sv
module host_port (
  input wire sys_clk,
  output logic sclk,
  output logic csb_n,
  output logic sdio_in,
  input wire sdio_out,
  input wire sdio_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    sclk = 1'b0;
    csb_n = 1'b1;
    sdio_in = 1'b0;
  end
  // Slow clock: each phase three cycles, stands still between frames
  task automatic frame(input bit rd, input logic [7:0] a, input logic [7:0] d,
      output logic [7:0] q);
    logic [23:0] sh;
    if (!rd && a == 8'h58 && d[6:5] == 2'b10) d[6] = 1'b0;
    sh = {rd, 7'h00, a, d};
    q = 8'h00;
    @(posedge sys_clk) #1 csb_n = 1'b0;
    for (int i = 23; i >= 0; i--) begin
      // Released line toggles so a stale bit cannot pass
      if (rd && i < 8) sdio_in = ~sdio_in;
      else sdio_in = sh[i];
      repeat (3) @(posedge sys_clk);
      #1 sclk = 1'b1;
      repeat (3) @(posedge sys_clk);
      // A line left undriven shows the opposite of the device's bit
      #1 if (i < 8) q[i] = sdio_oe ? sdio_out : ~sdio_out;
      sclk = 1'b0;
    end
    repeat (3) @(posedge sys_clk);
    #1 csb_n = 1'b1;
    repeat (4) @(posedge sys_clk);
  endtask
endmodule // host_port

// >>> bench/clock_dist_update_ctrl_test.sv
module clock_dist_update_ctrl_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 0, reset = 1, func_pin_n = 1, lost = 0;
  wire sclk, csb_n, sdio_in, sdio_out, sdio_oe, chip_reset_req, chip_powerdown;
  wire sync_hold, sync_pulse, sync_lost, sync_detect_en, sync_select, dist_ref_pd;
  wire sync_block_pd, delay_in_path, delay_pd;
  wire [4:0] divider_bypass, divider_pd, out_pd;
  wire [2:0] pecl_full_off;
  int num_errors = 0, checks = 0, seed = 80496, pulses = 0, pulses_exp = 0;
  int rl[3] = '{1, 3, 0};
  logic [7:0] am [0:255], bm [0:255], q;
  clock_dist_update_ctrl i_dut (.*);
  host_port i_host (.*);
  always #20 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (sync_pulse === 1'b1) pulses++;
  task automatic complete_run();
    if (num_errors == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    checks++;
    if (e !== s) begin
      num_errors++;
      $display("wrong value %s exp %h got %h", n, e, s);
    end
  endtask
  function automatic logic [7:0] msk(input logic [7:0] a);
    case (a)
      8'h58: msk = 8'h7f;
      8'h5a, 8'h62: msk = 8'h01;
      8'h60, 8'h61: msk = 8'h1f;
      8'h63: msk = 8'h07;
      default: msk = 8'h00;
    endcase
  endfunction
  function automatic logic [12:0] pdv(input logic [7:0] f, b, p, d);
    pdv = {f[4:3], b[4:0], p[4:0], ~d[0]};
  endfunction
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_host.frame(1'b0, a, d, q);
    bm[a] = d & msk(a);
  endtask
  task automatic rd(input logic [7:0] a);
    i_host.frame(1'b1, a, 8'h00, q);
    chk("read", bm[a], q);
  endtask
  task automatic chk_act();
    logic [7:0] f;
    f = am[8'h58];
    chk("fn", {3'h0, f[4:3], 1'b0, f[1:0]},
      {3'h0, sync_block_pd, dist_ref_pd, 1'b0, sync_select, sync_detect_en});
    chk("bypass", {3'h0, am[8'h60][4:0]}, {3'h0, divider_bypass});
    chk("div_pd", {3'h0, am[8'h60][4:0]}, {3'h0, divider_pd});
    chk("out_pd", {3'h0, am[8'h61][4:0]}, {3'h0, out_pd});
    chk("dly", {6'h0, am[8'h62][0], ~am[8'h62][0]}, {6'h0, delay_in_path, delay_pd});
    chk("off", {5'h0, am[8'h63][2:0]}, {5'h0, pecl_full_off});
    chk("lost", {7'h0, lost}, {7'h0, sync_lost});
    chk("hold", {7'h0, f[2]}, {7'h0, sync_hold});
  endtask
  task automatic upd();
    logic [12:0] o;
    logic [12:0] n;
    wr(8'h5a, 8'h01);
    chk_act();
    rd(8'h59);
    o = pdv(am[8'h58], am[8'h60], am[8'h61], am[8'h62]);
    n = pdv(bm[8'h58], bm[8'h60], bm[8'h61], bm[8'h62]);
    // Blocks power down with the copy; the soft sync edge lands a cycle later
    if (|(n & ~o)) lost = 1'b1;
    if (am[8'h58][2] && !bm[8'h58][2]) begin
      lost = 1'b0;
      pulses_exp++;
    end
    bm[8'h5a] = 8'h00;
    am = bm;
    chk_act();
    rd(8'h5a);
  endtask
  initial begin
    repeat (100000) @(posedge sys_clk);
    num_errors++;
    complete_run();
  end
  initial begin
    am = '{default: 8'h00};
    bm = '{default: 8'h00};
    repeat (8) @(posedge sys_clk);
    #1 reset = 1'b0;
    repeat (3) @(posedge sys_clk);
    chk_act();
    wr(8'h59, 8'hff);
    wr(8'h70, 8'h5a);
    rd(8'h59);
    rd(8'h70);
    repeat (4) begin
      for (int a = 8'h60; a < 8'h64; a++) wr(a[7:0], 8'($random(seed)));
      wr(8'h58, 8'($random(seed)) & 8'h9f);
      upd();
      for (int a = 8'h58; a < 8'h64; a++) rd(a[7:0]);
    end
    // Realign after the power-downs above
    wr(8'h58, 8'h04);
    upd();
    wr(8'h58, 8'h00);
    upd();
    for (int i = 0; i < 3; i++) begin
      wr(8'h58, {1'b0, 2'(rl[i]), 5'h00});
      upd();
      @(posedge sys_clk) #1 func_pin_n = 1'b0;
      repeat (4) @(posedge sys_clk);
      chk("role", {5'h0, rl[i] == 3, rl[i] == 1, rl[i] == 0},
        {5'h0, chip_powerdown, sync_hold, chip_reset_req});
      if (rl[i] == 3) lost = 1'b1;
      #1 func_pin_n = 1'b1;
      repeat (4) @(posedge sys_clk);
      if (rl[i] == 1) begin
        lost = 1'b0;
        pulses_exp++;
      end
      if (rl[i] == 0) begin
        am = '{default: 8'h00};
        bm = '{default: 8'h00};
        lost = 1'b0;
      end
      chk_act();
    end
    chk("pulses", pulses_exp[7:0], pulses[7:0]);
    complete_run();
  end
endmodule // clock_dist_update_ctrl_test
